// ---- hdl/uac_baud.sv ----
// eight-bit free-running baud timer, cleared by a divisor write
`timescale 1ns/1ps
module uac_baud (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] divisor,
   input  wire logic       restart,
   output logic            tick
);
   logic [7:0] cnt_q;
   wire        wrap;

   assign wrap = (cnt_q == uac_pkg::BRG_CLR);

   // count down, one tick every divisor+1 cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= uac_pkg::BAUD_RST;
         tick  <= 1'b0;
      end else if (restart) begin
         cnt_q <= uac_pkg::BRG_CLR;
         tick  <= 1'b0;
      end else begin
         tick  <= wrap;
         cnt_q <= wrap ? divisor : cnt_q - 8'h01;
      end
   end
endmodule

// ---- hdl/uac_usart.sv ----
// addressable usart: apb registers, async and sync serial engines
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module uac_usart (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tx_ck_in,
   output logic             tx_ck_out,
   output logic             tx_ck_oe_n,
   input  wire logic        rx_dt_in,
   output logic             rx_dt_out,
   output logic             rx_dt_oe_n
);
   uac_pkg::uac_rsc_s rsc_q;
   uac_pkg::uac_tsc_s tsc_q;
   uac_pkg::uac_rsc_s w_rsc;
   uac_pkg::uac_tsc_s w_tsc;
   uac_pkg::uac_rx_e  rx_st_q;
   logic [7:0]  baud_q;
   logic [1:0]  pdir_q;
   logic [7:0]  txb_q;
   logic        txb_full_q;
   logic [7:0]  rxd_q;
   logic        rx_full_q;
   logic [31:0] prdata_q;
   logic [1:0]  s1_q, s2_q, s3_q, flt_q, flp_q;
   logic        tick;
   logic [1:0]  pre_q;
   logic [1:0]  ph_q;
   logic        tx_busy_q;
   logic [3:0]  tx_left_q;
   logic [10:0] tsr_q;
   logic [3:0]  tx_os_q;
   logic [3:0]  rx_idx_q;
   logic [3:0]  rx_os_q;
   logic [2:0]  vote_q;
   logic [8:0]  rsr_q;
   logic        fe_q;
   logic        done_q;
   logic        ck_out_q, ck_oe_n_q, dt_out_q, dt_oe_n_q;

   // apb decode
   wire setup, acc, wr, rd;
   wire hit_rsc, hit_tsc, hit_baud, hit_pdir, hit_txd, hit_rxd, hit_stat;
   wire mapped, rd_rxd;
   wire [31:0] rd_val;
   assign setup    = psel & ~penable;
   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign hit_rsc  = (paddr == uac_pkg::OFF_RSC);
   assign hit_tsc  = (paddr == uac_pkg::OFF_TSC);
   assign hit_baud = (paddr == uac_pkg::OFF_BAUD);
   assign hit_pdir = (paddr == uac_pkg::OFF_PDIR);
   assign hit_txd  = (paddr == uac_pkg::OFF_TXD);
   assign hit_rxd  = (paddr == uac_pkg::OFF_RXD);
   assign hit_stat = (paddr == uac_pkg::OFF_STAT);
   assign mapped   = hit_rsc | hit_tsc | hit_baud | hit_pdir | hit_txd
                   | hit_rxd | hit_stat;
   assign rd_rxd   = rd & hit_rxd;
   assign w_rsc    = uac_pkg::uac_rsc_s'(pwdata[7:0]);
   assign w_tsc    = uac_pkg::uac_tsc_s'(pwdata[7:0]);
   assign pready   = 1'b1;
   assign pslverr  = acc & ~mapped;
   assign prdata   = prdata_q;

   // read selection
   assign rd_val = hit_rsc  ? {24'h000000, rsc_q} :
                   hit_tsc  ? {24'h000000, tsc_q} :
                   hit_baud ? {24'h000000, baud_q} :
                   hit_pdir ? {24'h000000, pdir_q, 6'h00} :
                   hit_rxd  ? {24'h000000, rxd_q} :
                   hit_stat ? {30'h00000000, txb_full_q, rx_full_q} :
                   32'h00000000;

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h00000000;
      else if (setup & ~pwrite) prdata_q <= rd_val;
   end

   // mode decode
   wire pins_en, is_sync, master, a_rx_en, s_rx_en, tx_en;
   assign pins_en = rsc_q.port_en & pdir_q[1] & pdir_q[0];
   assign is_sync = tsc_q.sync;
   assign master  = is_sync & tsc_q.clock_source_select;
   assign a_rx_en = pins_en & ~is_sync & rsc_q.continuous_receive_enable & ~rsc_q.overrun_error_flag;
   assign s_rx_en = pins_en & is_sync & ~rsc_q.overrun_error_flag
                  & (rsc_q.continuous_receive_enable | (rsc_q.one_shot_receive_enable & tsc_q.clock_source_select));
   assign tx_en   = pins_en & tsc_q.transmitter_enable & ~s_rx_en;

   // pin synchronisers, level accepted once stages two and three agree
   wire [1:0] pin_raw, rise, fall, stable;
   assign pin_raw = {rx_dt_in, tx_ck_in};
   assign stable  = ~(s2_q ^ s3_q);
   assign rise    = flt_q & ~flp_q;
   assign fall    = ~flt_q & flp_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q  <= 2'h3;
         s2_q  <= 2'h3;
         s3_q  <= 2'h3;
         flt_q <= 2'h3;
         flp_q <= 2'h3;
      end else begin
         s1_q  <= pin_raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         flt_q <= (s2_q & stable) | (flt_q & ~stable);
         flp_q <= flt_q;
      end
   end

   uac_baud u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .divisor (baud_q),
      .restart (wr & hit_baud),
      .tick    (tick)
   );

   // oversample enable: 16 per async bit, extra /4 at low speed
   wire os_en;
   assign os_en = tick
                & (tsc_q.high_speed_select | (pre_q == uac_pkg::LOW_PRE_LAST));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_q <= 2'h0;
      else if (wr & hit_baud) pre_q <= 2'h0;
      else if (tick) pre_q <= pre_q + 2'h1;
   end

   // sync master clock phases, four baud ticks per bit
   wire ck_run, samp_s, shift_s;
   assign ck_run  = master & (tx_busy_q | s_rx_en);
   assign samp_s  = master ? (tick & (ph_q == uac_pkg::PH_RISE))
                           : rise[0];
   assign shift_s = master ? (tick & (ph_q == uac_pkg::PH_FALL)) : fall[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ph_q <= 2'h0;
      else if (!ck_run) ph_q <= 2'h0;
      else if (tick) ph_q <= ph_q + 2'h1;
   end

   // transmit frame build
   wire        tx_load, tx_shift;
   wire [10:0] frame;
   wire [3:0]  frame_len;
   assign tx_load  = tx_en & txb_full_q & ~tx_busy_q;
   assign tx_shift = is_sync ? shift_s
                             : (os_en & (tx_os_q == uac_pkg::OS_LAST));
   assign frame = is_sync
      ? {2'b11, tsc_q.tx_ninth_bit, txb_q}
      : {1'b1, tsc_q.tx9 ? tsc_q.tx_ninth_bit : 1'b1, txb_q, 1'b0};
   assign frame_len = is_sync ? (tsc_q.tx9 ? uac_pkg::BITS9 : uac_pkg::BITS8)
                              : (tsc_q.tx9 ? uac_pkg::AFR9 : uac_pkg::AFR8);

   // transmit shift register, lsb first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy_q <= 1'b0;
         tx_left_q <= 4'h0;
         tsr_q     <= 11'h7ff;
         tx_os_q   <= 4'h0;
      end else if (!tx_en) begin
         tx_busy_q <= 1'b0;
      end else if (tx_load) begin
         tsr_q     <= frame;
         tx_left_q <= frame_len;
         tx_busy_q <= 1'b1;
         tx_os_q   <= 4'h0;
      end else if (tx_busy_q) begin
         if (os_en) tx_os_q <= tx_os_q + 4'h1;
         if (tx_shift) begin
            tsr_q     <= {1'b1, tsr_q[10:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) tx_busy_q <= 1'b0;
         end
      end
   end

   // transmit holding buffer, a new write overwrites
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txb_q      <= 8'h00;
         txb_full_q <= 1'b0;
      end else if (wr & hit_txd) begin
         txb_q      <= pwdata[7:0];
         txb_full_q <= 1'b1;
      end else if (tx_load) begin
         txb_full_q <= 1'b0;
      end
   end

   // receiver: bit count and majority vote
   wire [3:0] rx_bits;
   wire       maj, a_start, a_vote, a_decide;
   assign rx_bits  = rsc_q.rx9 ? uac_pkg::BITS9 : uac_pkg::BITS8;
   assign maj      = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2])
                   | (vote_q[1] & vote_q[2]);
   assign a_start  = a_rx_en & fall[1];
   assign a_vote   = os_en & ((rx_os_q == uac_pkg::VOTE_A)
                   | (rx_os_q == uac_pkg::VOTE_B)
                   | (rx_os_q == uac_pkg::VOTE_C));
   assign a_decide = os_en & (rx_os_q == uac_pkg::DECIDE);

   // receive shift register, sync and async
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q  <= uac_pkg::RX_IDLE;
         rx_idx_q <= 4'h0;
         rx_os_q  <= 4'h0;
         vote_q   <= 3'h7;
         rsr_q    <= 9'h000;
         fe_q     <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!(a_rx_en | s_rx_en)) begin
            rx_st_q  <= uac_pkg::RX_IDLE;
            rx_idx_q <= 4'h0;
         end else if (is_sync) begin
            if (samp_s) begin
               rsr_q[rx_idx_q] <= flt_q[1];
               rx_idx_q <= rx_idx_q + 4'h1;
               if (rx_idx_q == rx_bits - 4'h1) begin
                  rx_idx_q <= 4'h0;
                  fe_q     <= 1'b0;
                  done_q   <= 1'b1;
               end
            end
         end else begin
            unique case (rx_st_q)
               uac_pkg::RX_IDLE: begin
                  if (a_start) begin
                     rx_st_q  <= uac_pkg::RX_FRAME;
                     rx_os_q  <= 4'h0;
                     rx_idx_q <= 4'h0;
                  end
               end
               uac_pkg::RX_FRAME: begin
                  if (os_en) rx_os_q <= rx_os_q + 4'h1;
                  if (a_vote) vote_q <= {vote_q[1:0], flt_q[1]};
                  if (a_decide) begin
                     rx_idx_q <= rx_idx_q + 4'h1;
                     if (rx_idx_q == 4'h0 && maj) begin
                        rx_st_q <= uac_pkg::RX_IDLE; // false start
                     end else if (rx_idx_q == rx_bits + 4'h1) begin
                        rx_st_q <= uac_pkg::RX_IDLE;
                        fe_q    <= ~maj;
                        done_q  <= 1'b1;
                     end else if (rx_idx_q != 4'h0) begin
                        rsr_q[rx_idx_q - 4'h1] <= maj;
                     end
                  end
               end
            endcase
         end
      end
   end

   // character acceptance, address filter and overrun
   wire addr_skip, take, ovr, ld_ok, one_shot_receive_enable_clr;
   assign addr_skip = ~is_sync & rsc_q.rx9 & rsc_q.address_detect_enable & ~rsr_q[8];
   assign take      = done_q & ~addr_skip;
   assign ovr       = take & rx_full_q & ~rd_rxd;
   assign ld_ok     = take & ~ovr;
   assign one_shot_receive_enable_clr  = done_q & master & ~rsc_q.continuous_receive_enable;

   // receive data buffer, emptied by a read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_q     <= 8'h00;
         rx_full_q <= 1'b0;
      end else if (ld_ok) begin
         rxd_q     <= rsr_q[7:0];
         rx_full_q <= 1'b1;
      end else if (rd_rxd) begin
         rx_full_q <= 1'b0;
      end
   end

   // receive status/control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsc_q <= uac_pkg::uac_rsc_s'(uac_pkg::RSC_RST);
      end else begin
         if (one_shot_receive_enable_clr) rsc_q.one_shot_receive_enable <= 1'b0;
         if (wr & hit_rsc) begin
            rsc_q.port_en <= w_rsc.port_en;
            rsc_q.rx9     <= w_rsc.rx9;
            rsc_q.one_shot_receive_enable    <= w_rsc.one_shot_receive_enable;
            rsc_q.continuous_receive_enable    <= w_rsc.continuous_receive_enable;
            rsc_q.address_detect_enable   <= w_rsc.address_detect_enable;
         end
         if (ld_ok) begin
            rsc_q.framing_error_flag <= fe_q;
            rsc_q.rx_ninth_bit <= rsc_q.rx9 & rsr_q[8];
         end
         if (ovr) rsc_q.overrun_error_flag <= 1'b1;
         else if (!rsc_q.continuous_receive_enable) rsc_q.overrun_error_flag <= 1'b0;
      end
   end

   // transmit status/control register and other settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsc_q  <= uac_pkg::uac_tsc_s'(uac_pkg::TSC_RST);
         baud_q <= uac_pkg::BAUD_RST;
         pdir_q <= uac_pkg::PDIR_RST;
      end else begin
         tsc_q.shift_register_empty <= ~tx_busy_q;
         if (wr & hit_tsc) begin
            tsc_q.clock_source_select <= w_tsc.clock_source_select;
            tsc_q.tx9  <= w_tsc.tx9;
            tsc_q.transmitter_enable <= w_tsc.transmitter_enable;
            tsc_q.sync <= w_tsc.sync;
            tsc_q.high_speed_select <= w_tsc.high_speed_select;
            tsc_q.tx_ninth_bit <= w_tsc.tx_ninth_bit;
         end
         if (wr & hit_baud) baud_q <= pwdata[7:0];
         if (wr & hit_pdir)
            pdir_q <= pwdata[uac_pkg::PDIR_HI:uac_pkg::PDIR_LO];
      end
   end

   // pin drivers, enable low while driving
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_out_q  <= 1'b1;
         ck_oe_n_q <= 1'b1;
         dt_out_q  <= 1'b1;
         dt_oe_n_q <= 1'b1;
      end else begin
         ck_out_q  <= is_sync ? ph_q[1] : (~tx_busy_q | tsr_q[0]);
         ck_oe_n_q <= ~(pins_en & (~is_sync | master));
         dt_out_q  <= tsr_q[0];
         dt_oe_n_q <= ~(pins_en & is_sync & tx_busy_q);
      end
   end

   assign tx_ck_out  = ck_out_q;
   assign tx_ck_oe_n = ck_oe_n_q;
   assign rx_dt_out  = dt_out_q;
   assign rx_dt_oe_n = dt_oe_n_q;
endmodule

// ---- pkg/uac_pkg.sv ----
// package: register map, field layouts and timing of the usart
package uac_pkg;
   // byte addresses of the registers on the apb bus
   localparam logic [7:0] OFF_TXD  = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_RSC  = 8'h18;
   localparam logic [7:0] OFF_RXD  = 8'h1c;
   localparam logic [7:0] OFF_PDIR = 8'h94;
   localparam logic [7:0] OFF_TSC  = 8'h98;
   localparam logic [7:0] OFF_BAUD = 8'h9c;

   // reset values
   localparam logic [7:0] RSC_RST  = 8'h00;
   localparam logic [7:0] TSC_RST  = 8'h02;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] BRG_CLR  = 8'h00;
   localparam logic [1:0] PDIR_RST = 2'h0;

   // pin direction bits sit at 7:6 of their register
   localparam int PDIR_HI = 7;
   localparam int PDIR_LO = 6;

   // timing: 16 oversample slots per async bit, low speed adds /4
   localparam logic [1:0] LOW_PRE_LAST = 2'h3;
   localparam logic [3:0] OS_LAST      = 4'hf;
   localparam logic [3:0] VOTE_A       = 4'h7;
   localparam logic [3:0] VOTE_B       = 4'h8;
   localparam logic [3:0] VOTE_C       = 4'h9;
   localparam logic [3:0] DECIDE       = 4'ha;
   // sync bit: four baud ticks, clock low in phases 0..1
   localparam logic [1:0] PH_RISE      = 2'h1;
   localparam logic [1:0] PH_FALL      = 2'h3;

   // bit counts per character and per async frame
   localparam logic [3:0] BITS8 = 4'h8;
   localparam logic [3:0] BITS9 = 4'h9;
   localparam logic [3:0] AFR8  = 4'ha;
   localparam logic [3:0] AFR9  = 4'hb;

   // receive status/control layout, bit 7 first
   typedef struct packed {
      logic port_en;
      logic rx9;
      logic one_shot_receive_enable;
      logic continuous_receive_enable;
      logic address_detect_enable;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic rx_ninth_bit;
   } uac_rsc_s;

   // transmit status/control layout, bit 7 first
   typedef struct packed {
      logic clock_source_select;
      logic tx9;
      logic transmitter_enable;
      logic sync;
      logic rsvd;
      logic high_speed_select;
      logic shift_register_empty;
      logic tx_ninth_bit;
   } uac_tsc_s;

   // async receiver states
   typedef enum logic {RX_IDLE, RX_FRAME} uac_rx_e;
endpackage

// ---- tb/addressable_usart_control_tb_top.sv ----
// testbench: register, async and sync link scenarios for the usart
`timescale 1ns/1ps
module addressable_usart_control_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, e;
   logic        ck_o, ck_oe_n, dt_o, dt_oe_n;
   logic        ck_dr, ck_en, dt_dr, dt_en;
   logic [9:0]  v;
   wire         ck_w, dt_w;
   int          n_fail = 0;
   int          cmp_count = 0;
   // pin levels: clock line pulled down, data line pulled up
   assign ck_w = !ck_oe_n ? ck_o : ck_en ? ck_dr : 1'b0;
   assign dt_w = !dt_oe_n ? dt_o : dt_en ? dt_dr : 1'b1;
   uac_usart uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_ck_in(ck_w),
      .tx_ck_out(ck_o), .tx_ck_oe_n(ck_oe_n), .rx_dt_in(dt_w),
      .rx_dt_out(dt_o), .rx_dt_oe_n(dt_oe_n));
   uac_link_partner lp (
      .ck_w(ck_w), .dt_w(dt_w), .ck_dr(ck_dr), .ck_en(ck_en),
      .dt_dr(dt_dr), .dt_en(dt_en));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task chk(input string n, input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   // one apb transfer, access held until pready
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), r, {24'h0, x});
   endtask
   // poll status until a character is buffered
   task wait_rx;
      r = '0;
      for (int i = 0; i < 300 && r[0] !== 1'b1; i++)
         apb(1'b0, uac_pkg::OFF_STAT, 8'h00);
   endtask
   // send one character, partner decodes the frame
   task tx_chk(input logic [7:0] t, input logic [7:0] x, input int nb,
               input int bt, input logic [9:0] f);
      wr(uac_pkg::OFF_BAUD, x);
      wr(uac_pkg::OFF_TSC, t);
      fork
         lp.recv_async(nb, bt, v);
         begin
            wr(uac_pkg::OFF_TXD, f[7:0]);
            repeat (4) @(posedge pclk);
            rc(uac_pkg::OFF_TSC, t);
         end
      join
      chk("frame", {22'h0, v}, {22'h0, f});
      repeat (bt / 10) @(posedge pclk);
      rc(uac_pkg::OFF_TSC, t | 8'h02);
   endtask
   // receive one async character, check status and data
   task rx_chk(input logic [8:0] d, input int nb, input logic s,
               input logic [7:0] st);
      lp.send_async(d, nb, s, 160);
      wait_rx;
      rc(uac_pkg::OFF_RSC, st);
      rc(uac_pkg::OFF_RXD, d[7:0]);
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog well above the longest expected run
   initial begin
      #400000;
      n_fail++;
      $display("Error watchdog expired");
      results;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rc(uac_pkg::OFF_RSC, 8'h00);
      rc(uac_pkg::OFF_TSC, 8'h02);
      rc(uac_pkg::OFF_BAUD, 8'h00);
      apb(1'b0, 8'h40, 8'h00);
      chk("unmapped error", {31'h0, e}, 32'h1);
      chk("unmapped data", r, 32'h0);
      wr(uac_pkg::OFF_TSC, 8'hff);
      rc(uac_pkg::OFF_TSC, 8'hf7);
      wr(uac_pkg::OFF_RSC, 8'h7f);
      rc(uac_pkg::OFF_RSC, 8'h78);
      wr(uac_pkg::OFF_RSC, 8'h00);
      $display("test registers done");
      wr(uac_pkg::OFF_PDIR, 8'hc0);
      wr(uac_pkg::OFF_TSC, 8'h24);
      wr(uac_pkg::OFF_RSC, 8'h80);
      tx_chk(8'h65, 8'h00, 9, 160, 10'h3a5);
      tx_chk(8'h20, 8'h01, 8, 1280, 10'h15c);
      $display("test transmit done");
      wr(uac_pkg::OFF_TSC, 8'h04);
      wr(uac_pkg::OFF_BAUD, 8'h00);
      wr(uac_pkg::OFF_RSC, 8'h90);
      rx_chk(9'h03c, 8, 1'b1, 8'h90);
      rx_chk(9'h05a, 8, 1'b0, 8'h94);
      lp.send_async(9'h011, 8, 1'b1, 160);
      lp.send_async(9'h022, 8, 1'b1, 160);
      rc(uac_pkg::OFF_RSC, 8'h92);
      rc(uac_pkg::OFF_RXD, 8'h11);
      wr(uac_pkg::OFF_RSC, 8'h80);
      rc(uac_pkg::OFF_RSC, 8'h80);
      wr(uac_pkg::OFF_RSC, 8'hd8);
      lp.send_async(9'h0aa, 9, 1'b1, 160);
      rc(uac_pkg::OFF_STAT, 8'h00);
      rx_chk(9'h155, 9, 1'b1, 8'hd9);
      wr(uac_pkg::OFF_RSC, 8'hd0);
      rx_chk(9'h0c3, 9, 1'b1, 8'hd0);
      $display("test receive done");
      wr(uac_pkg::OFF_RSC, 8'h80);
      wr(uac_pkg::OFF_TSC, 8'h90);
      wr(uac_pkg::OFF_BAUD, 8'h03);
      fork
         lp.serve_sync(8'h96);
         wr(uac_pkg::OFF_RSC, 8'ha0);
      join
      wait_rx;
      rc(uac_pkg::OFF_RSC, 8'h80);
      rc(uac_pkg::OFF_RXD, 8'h96);
      wr(uac_pkg::OFF_TSC, 8'hb0);
      fork
         lp.recv_sync(v);
         wr(uac_pkg::OFF_TXD, 8'ha5);
      join
      chk("sync frame", {22'h0, v}, 32'h000000a5);
      wr(uac_pkg::OFF_TSC, 8'h10);
      wr(uac_pkg::OFF_RSC, 8'h90);
      lp.clock_in(8'h69);
      wait_rx;
      rc(uac_pkg::OFF_RXD, 8'h69);
      rc(uac_pkg::OFF_RSC, 8'h90);
      $display("test sync done");
      results;
   end
endmodule

// ---- tb/uac_link_partner.sv ----
// partner: serial terminal or memory on the far side of the pins
`timescale 1ns/1ps
module uac_link_partner (
   input  wire logic ck_w,
   input  wire logic dt_w,
   output logic      ck_dr,
   output logic      ck_en,
   output logic      dt_dr,
   output logic      dt_en
);
   // all lines released at start
   initial begin
      ck_dr = 1'b0;
      ck_en = 1'b0;
      dt_dr = 1'b1;
      dt_en = 1'b0;
   end
   // async frame: start, data lsb first, stop, then release
   task send_async(input logic [8:0] d, input int nb, input logic s,
                   input int bt);
      dt_en = 1'b1;
      dt_dr = 1'b0;
      #bt;
      for (int i = 0; i < nb; i++) begin
         dt_dr = d[i];
         #bt;
      end
      dt_dr = s;
      #bt;
      dt_dr = 1'b1;
      #bt;
      dt_en = 1'b0;
   endtask
   // decode an async frame at mid-bit; stop bit lands in v[nb]
   task recv_async(input int nb, input int bt, output logic [9:0] v);
      v = '0;
      @(negedge ck_w);
      #(bt / 2);
      for (int i = 0; i <= nb; i++) begin
         #bt;
         v[i] = ck_w;
      end
   endtask
   // feed a clocking master: new bit after each fall
   task serve_sync(input logic [7:0] d);
      dt_en = 1'b1;
      dt_dr = d[0];
      for (int i = 1; i < 9; i++) begin
         @(negedge ck_w);
         dt_dr = i < 8 ? d[i] : 1'b1;
      end
      dt_en = 1'b0;
   endtask
   // capture a clocking master's byte at each rising clock
   task recv_sync(output logic [9:0] v);
      v = '0;
      for (int i = 0; i < 8; i++) begin
         @(posedge ck_w);
         v[i] = dt_w;
      end
   endtask
   // clock a character into a slave at an 80 ns period
   task clock_in(input logic [7:0] d);
      ck_en = 1'b1;
      dt_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         dt_dr = d[i];
         #20;
         ck_dr = 1'b1;
         #40;
         ck_dr = 1'b0;
         #20;
      end
      ck_en = 1'b0;
      dt_en = 1'b0;
   endtask
endmodule

// ---- tb/uac_usart_assertions.sv ----
// checker: port-level assertions for the usart, bound to its top
`timescale 1ns/1ps
module uac_usart_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tx_ck_in,
   input wire logic        tx_ck_out,
   input wire logic        tx_ck_oe_n,
   input wire logic        rx_dt_in,
   input wire logic        rx_dt_out,
   input wire logic        rx_dt_oe_n
);
   logic       pe_q;
   logic       sync_q;
   logic       clock_source_select_q;
   logic [1:0] dir_q;
   // bus phase decode and pin routing state
   wire acc  = psel && penable;
   wire rd   = acc && !pwrite;
   wire en   = pe_q && dir_q == 2'h3;
   wire slv  = sync_q && !clock_source_select_q;
   wire mapd = paddr inside {uac_pkg::OFF_TXD, uac_pkg::OFF_STAT,
      uac_pkg::OFF_RSC, uac_pkg::OFF_RXD, uac_pkg::OFF_PDIR,
      uac_pkg::OFF_TSC, uac_pkg::OFF_BAUD};
   // mirror of mode bits written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pe_q   <= 1'b0;
         dir_q  <= 2'h0;
         sync_q <= 1'b0;
         clock_source_select_q <= 1'b0;
      end else if (acc && pwrite) begin
         if (paddr == uac_pkg::OFF_RSC) pe_q <= pwdata[7];
         if (paddr == uac_pkg::OFF_PDIR) dir_q <= pwdata[7:6];
         if (paddr == uac_pkg::OFF_TSC) sync_q <= pwdata[4];
         if (paddr == uac_pkg::OFF_TSC) clock_source_select_q <= pwdata[7];
      end
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (acc && !mapd |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (psel && mapd |-> !pslverr)
      else $error("error on mapped access");
   a_rd_upper: assert property (rd |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_rd_hold: assert property (rd |=> $stable(prdata))
      else $error("read data moved after access");
   a_pins_idle: assert property (!en && !$past(en)
      |-> tx_ck_oe_n && rx_dt_oe_n) else $error("pins driven");
   a_async_low: assert property ($fell(tx_ck_out) && en
      && !sync_q && !tx_ck_oe_n |-> (!tx_ck_out) [*8])
      else $error("async bit too short");
   a_mclk_high: assert property ($rose(tx_ck_out) && en
      && sync_q && clock_source_select_q && !tx_ck_oe_n |-> tx_ck_out [*2])
      else $error("master clock high too short");
   a_slave_pin: assert property (en && slv && $past(slv)
      |-> tx_ck_oe_n) else $error("slave drives clock pin");
endmodule
bind uac_usart uac_usart_assertions chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_ck_in(tx_ck_in),
   .tx_ck_out(tx_ck_out), .tx_ck_oe_n(tx_ck_oe_n), .rx_dt_in(rx_dt_in),
   .rx_dt_out(rx_dt_out), .rx_dt_oe_n(rx_dt_oe_n));
